// ==== src/spe_defs.vh ====
/*
 defines shared by the serial nonvolatile memory command logic.
 assumes inclusion by bare name from the design files only.
*/
`ifndef SPE_DEFS_VH
`define SPE_DEFS_VH
// opcode low three bits, upper nibble must be zero
`define SPE_OP_LATCH_SET 3'h6
`define SPE_OP_LATCH_CLR 3'h4
`define SPE_OP_STAT_RD 3'h5
`define SPE_OP_STAT_WR 3'h1
`define SPE_OP_READ 3'h3
`define SPE_OP_WRITE 3'h2
// status bit positions
`define SPE_SR_BUSY 0
`define SPE_SR_LATCH 1
`define SPE_SR_PLO 2
`define SPE_SR_PHI 3
// factory values
`define SPE_ERASED_BYTE 8'hFF
`define SPE_FACTORY_PROT 2'h0
// program time in microseconds and core clock rate in MHz
`define SPE_TW_US 5000
`define SPE_CLK_MHZ 100
`define SPE_TW_CYC (`SPE_TW_US * `SPE_CLK_MHZ)
`define SPE_PAGE_BYTES 16
`define SPE_MEM_BYTES 512
`endif

// ==== src/spe_mem.v ====
/*
 nonvolatile byte array model: one write port, one registered read port.
 assumes it runs on the core clock; contents survive the block reset.
*/
`timescale 1ns/1ns
`include "spe_defs.vh"
module spe_mem #(
   parameter AW = 9
) (
   input wire ref_clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [7:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [7:0] rdata
);
   reg [7:0] cells [0:(1<<AW)-1];
   integer i;
   // factory state: every byte erased to all ones
   initial begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
         cells[i] = `SPE_ERASED_BYTE;
      end
      rdata = `SPE_ERASED_BYTE;
   end
   // synchronous write and registered read
   always @(posedge ref_clk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
      rdata <= cells[raddr];
   end
endmodule

// ==== src/spe_core.v ====
/*
 command logic of a serial nonvolatile memory on an spi mode 0/3 link.
 assumes link pins arrive asynchronous to ref_clk, slower than ref_clk/8.
*/
`timescale 1ns/1ns
`include "spe_defs.vh"
// Behaviour
// RULE_01 - status write ignored unless the write latch is set
// RULE_02 - status write runs only if select rises right after eighth data bit
// RULE_03 - accepted status write starts a self-timed program cycle
// RULE_04 - busy flag reads one during the cycle, zero after; status stays readable
// RULE_05 - write latch clears when the status write cycle ends
// RULE_06 - protect bits update only after the full program time
// RULE_07 - status write keeps other bits; top nibble reads zero
// RULE_08 - status write refused if latch clear, busy, or protect pin low
// RULE_09 - read is opcode plus one address byte; top address bit in opcode bit 3
// RULE_10 - after address, bytes shift out continuously while selected
// RULE_11 - read address wraps from highest address to zero
// RULE_12 - select rising ends a read at any point
// RULE_13 - read ignored while a program cycle runs
// RULE_14 - address width follows memory size; upper bits ignored
// RULE_15 - write is opcode, address, data bytes; select rise at byte boundary starts cycle
// RULE_16 - extra bytes fill the page and wrap to the page start
// RULE_17 - write refused if latch clear, busy, misaligned end, pin low, or protected
// RULE_18 - program cycle erases then programs the addressed bytes
// RULE_19 - after reset device is deselected until a falling select edge
// RULE_20 - reset clears write latch and busy flag
// RULE_21 - protect bits survive reset
// RULE_22 - factory state: array all ones, protect bits zero
// RULE_23 - only the latch-set command sets the write latch
// RULE_24 - protect setting maps to none, upper quarter, upper half, all
// RULE_25 - opcode decode; unknown opcode deselects the device
// RULE_26 - program time is a parameter in core clock cycles
// RULE_27 - page size is a parameter, default sixteen bytes
// RULE_28 - memory size is a parameter setting address width and wrap
module spe_core #(
   parameter MEM_BYTES = `SPE_MEM_BYTES,
   parameter PAGE_BYTES = `SPE_PAGE_BYTES,
   parameter TW_CYC = `SPE_TW_CYC
) (
   input wire ref_clk,
   input wire resetn,
   input wire sel_n,
   input wire sclk,
   input wire sdi,
   input wire wp_n,
   output reg sdo_r,
   output reg sdo_oe_r,
   output reg busy_r,
   output reg [7:0] status_r
);
   // RULE_28 size sets width
   localparam AW = (MEM_BYTES > 256) ? 9 : ((MEM_BYTES > 128) ? 8 : 7);
   // RULE_27 page size parameter
   localparam PW = (PAGE_BYTES > 1) ? $clog2(PAGE_BYTES) : 1;
   localparam [AW-1:0] PMASK = PAGE_BYTES - 1;
   // one-hot states
   localparam [7:0] S_IDLE = 8'h01, S_OPC = 8'h02, S_ADDR = 8'h04, S_RDAT = 8'h08;
   localparam [7:0] S_WDAT = 8'h10, S_SDAT = 8'h20, S_STAT = 8'h40, S_WAIT = 8'h80;
   localparam [2:0] P_IDLE = 3'h1, P_ERASE = 3'h2, P_PROG = 3'h4;

   // two-flop synchronisers; first stage read only by second
   reg [3:0] s1_r, s2_r;
   reg sclk_d_r, sel_d_r;
   wire sel_s = s2_r[0];
   wire sclk_s = s2_r[1];
   wire sdi_s = s2_r[2];
   wire wp_s = s2_r[3];
   wire rise = sclk_s & ~sclk_d_r & ~sel_s;
   wire fall = ~sclk_s & sclk_d_r & ~sel_s;
   wire sel_up = sel_s & ~sel_d_r;
   wire sel_down = ~sel_s & sel_d_r;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s1_r <= 4'hD; // clock image idles low, so no false edge follows reset
         s2_r <= 4'hD;
         sclk_d_r <= 1'b0;
         sel_d_r <= 1'b1;
      end else begin
         s1_r <= {wp_n, sdi, sclk, sel_n};
         s2_r <= s1_r;
         sclk_d_r <= sclk_s;
         sel_d_r <= sel_s;
      end
   end

   reg [7:0] st_r;
   reg [7:0] sh_r;
   reg [2:0] cnt_r;
   reg [2:0] op_r;
   reg [AW-1:0] addr_r;
   reg [AW-1:0] base_r;
   reg [PW:0] nbytes_r;
   reg [7:0] pbuf_r [0:PAGE_BYTES-1];
   reg [PAGE_BYTES-1:0] pval_r;
   reg latch_r;
   reg [1:0] prot_r;
   reg [1:0] newprot_r;
   reg wp_seen_r;
   reg aligned_r;
   reg [7:0] obyte_r;
   reg [2:0] ph_r;
   reg is_sr_r;
   reg [31:0] tcnt_r;
   reg [PW-1:0] pidx_r;
   reg mem_we;
   reg [7:0] mem_wd;
   wire [7:0] mem_rd;
   wire [7:0] sh_nxt = {sh_r[6:0], sdi_s};
   wire busy = (ph_r != P_IDLE);
   wire [AW-1:0] waddr = (base_r & ~PMASK) | {{(AW-PW){1'b0}}, pidx_r};
   // opcode-borne top bit joined to the address byte; only the low AW bits are kept
   wire [8:0] addr_full = {addr_r[AW-1], sh_nxt};

   // RULE_24 protected range check
   function prot_hit;
      input [1:0] p;
      input [AW-1:0] a;
      begin
         case (p)
            2'b01: prot_hit = (a[AW-1:AW-2] == 2'b11);
            2'b10: prot_hit = a[AW-1];
            2'b11: prot_hit = 1'b1;
            default: prot_hit = 1'b0;
         endcase
      end
   endfunction

   // RULE_22 factory protect bits zero; RULE_21 kept across resets
   initial prot_r = `SPE_FACTORY_PROT;

   // RULE_18 array storage
   spe_mem #(.AW(AW)) u_mem (
      .ref_clk(ref_clk),
      .we(mem_we),
      .waddr(waddr),
      .wdata(mem_wd),
      .raddr(addr_r),
      .rdata(mem_rd)
   );

   // RULE_18 erase pass writes zero, program pass writes data
   always @* begin
      mem_we = 1'b0;
      mem_wd = 8'h00;
      if (!is_sr_r && pval_r[pidx_r]) begin
         mem_we = (ph_r == P_ERASE) | (ph_r == P_PROG);
         mem_wd = (ph_r == P_PROG) ? pbuf_r[pidx_r] : 8'h00;
      end
   end

   // serial command engine and program timer
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         // RULE_19 RULE_20 deselected, latch and busy clear
         st_r <= S_IDLE;
         sh_r <= 8'h00;
         cnt_r <= 3'h0;
         op_r <= 3'h0;
         addr_r <= {AW{1'b0}};
         base_r <= {AW{1'b0}};
         nbytes_r <= {(PW+1){1'b0}};
         pval_r <= {PAGE_BYTES{1'b0}};
         latch_r <= 1'b0;
         newprot_r <= 2'h0;
         wp_seen_r <= 1'b0;
         aligned_r <= 1'b0;
         obyte_r <= 8'h00;
         ph_r <= P_IDLE;
         is_sr_r <= 1'b0;
         tcnt_r <= 32'h0000_0000;
         pidx_r <= {PW{1'b0}};
         sdo_r <= 1'b0;
         sdo_oe_r <= 1'b0;
      end else begin
         if (!wp_s) begin
            wp_seen_r <= 1'b1;
         end
         // RULE_03 RULE_26 timed erase then program, one pass per page slot
         if (ph_r != P_IDLE) begin
            if (pidx_r != PMASK[PW-1:0]) begin
               pidx_r <= pidx_r + 1'b1;
            end else if (ph_r == P_ERASE) begin
               ph_r <= P_PROG;
               pidx_r <= {PW{1'b0}};
            end else if (tcnt_r >= TW_CYC - 1) begin
               // RULE_04 RULE_05 RULE_06 cycle end clears busy and latch, loads protect bits after a status write
               ph_r <= P_IDLE;
               latch_r <= 1'b0;
               if (is_sr_r) begin
                  prot_r <= newprot_r;
               end
            end
            tcnt_r <= tcnt_r + 1;
         end
         if (sel_down) begin
            // RULE_19 command starts only on a falling select
            st_r <= S_OPC;
            cnt_r <= 3'h0;
            wp_seen_r <= ~wp_s;
            aligned_r <= 1'b0;
            op_r <= 3'h0;
            // a frame opened during a program cycle must not wipe the page image in use
            if (!busy) begin
               nbytes_r <= {(PW+1){1'b0}};
               pval_r <= {PAGE_BYTES{1'b0}};
            end
         end else if (sel_up) begin
            // RULE_12 select high ends any command frame; a running program cycle continues
            st_r <= S_IDLE;
            sdo_oe_r <= 1'b0;
            if (!busy && latch_r && !wp_seen_r && aligned_r) begin
               // RULE_01 RULE_02 RULE_08 status write accepted; a whole data byte parks in S_WAIT
               if (st_r == S_WAIT) begin
                  ph_r <= P_ERASE;
                  is_sr_r <= 1'b1;
                  tcnt_r <= 32'h0000_0000;
                  pidx_r <= {PW{1'b0}};
               end
               // RULE_15 RULE_17 array write accepted
               if (st_r == S_WDAT && nbytes_r != 0 && !prot_hit(prot_r, base_r)) begin
                  ph_r <= P_ERASE;
                  is_sr_r <= 1'b0;
                  tcnt_r <= 32'h0000_0000;
                  pidx_r <= {PW{1'b0}};
               end
            end
            if (st_r == S_OPC && cnt_r == 3'h0 && op_r == `SPE_OP_LATCH_CLR) begin
               latch_r <= 1'b0;
            end
            // RULE_23 latch set only by its own command
            if (st_r == S_OPC && cnt_r == 3'h0 && op_r == `SPE_OP_LATCH_SET && !busy) begin
               latch_r <= 1'b1;
            end
         end else if (rise) begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_r + 1'b1;
            aligned_r <= (cnt_r == 3'h7);
            if (cnt_r == 3'h7) begin
               case (st_r)
                  S_OPC: begin
                     op_r <= sh_nxt[2:0];
                     // RULE_09 top address bit rides in opcode bit 3
                     addr_r[AW-1] <= (AW == 9) ? sh_nxt[3] : 1'b0;
                     // RULE_25 decode, unknown opcode deselects
                     if (sh_nxt[7:4] != 4'h0) begin
                        st_r <= S_IDLE;
                     end else if (sh_nxt[2:0] == `SPE_OP_READ || sh_nxt[2:0] == `SPE_OP_WRITE) begin
                        // RULE_13 array access ignored while busy
                        st_r <= busy ? S_IDLE : S_ADDR;
                     end else if (sh_nxt[2:0] == `SPE_OP_STAT_WR) begin
                        st_r <= S_SDAT;
                     end else if (sh_nxt[2:0] == `SPE_OP_STAT_RD) begin
                        st_r <= S_STAT;
                        obyte_r <= status_r;
                     end else if (sh_nxt[2:0] == `SPE_OP_LATCH_SET || sh_nxt[2:0] == `SPE_OP_LATCH_CLR) begin
                        // done at select rise; cnt 0 marks a clean eight bits
                        st_r <= S_OPC;
                     end else begin
                        st_r <= S_IDLE;
                     end
                     if (sh_nxt[2:0] != `SPE_OP_LATCH_SET && sh_nxt[2:0] != `SPE_OP_LATCH_CLR) begin
                        op_r <= 3'h0;
                     end
                     if (sh_nxt[2:0] == `SPE_OP_READ || sh_nxt[2:0] == `SPE_OP_WRITE) begin
                        op_r <= sh_nxt[2:0];
                     end
                  end
                  S_ADDR: begin
                     // RULE_14 address bits above the size are dropped
                     addr_r <= addr_full[AW-1:0];
                     base_r <= addr_full[AW-1:0];
                     st_r <= (op_r == `SPE_OP_READ) ? S_RDAT : S_WDAT;
                  end
                  S_WDAT: begin
                     // RULE_16 page buffer wraps to the page start
                     pbuf_r[(base_r[PW-1:0] + nbytes_r[PW-1:0])] <= sh_nxt;
                     pval_r[(base_r[PW-1:0] + nbytes_r[PW-1:0])] <= 1'b1;
                     if (nbytes_r != PAGE_BYTES) begin
                        nbytes_r <= nbytes_r + 1'b1;
                     end
                  end
                  S_SDAT: begin
                     // RULE_07 only the protect bits are taken
                     // a refused write during a status cycle must not alter the pending bits
                     if (!busy) begin
                        newprot_r <= sh_nxt[`SPE_SR_PHI:`SPE_SR_PLO];
                     end
                     st_r <= S_WAIT;
                  end
                  default: begin
                     st_r <= st_r;
                  end
               endcase
            end else if (st_r == S_WAIT) begin
               // RULE_02 clock after the data byte voids the status write
               st_r <= S_IDLE;
            end
         end else if (fall) begin
            // RULE_10 shift out msb first on falling edges
            if (st_r == S_RDAT || st_r == S_STAT) begin
               sdo_oe_r <= 1'b1;
               sdo_r <= obyte_r[7];
               obyte_r <= {obyte_r[6:0], 1'b0};
               if (cnt_r == 3'h0 && st_r == S_STAT) begin
                  sdo_r <= status_r[7];
                  obyte_r <= {status_r[6:0], 1'b0};
               end
               if (cnt_r == 3'h0 && st_r == S_RDAT) begin
                  sdo_r <= mem_rd[7];
                  obyte_r <= {mem_rd[6:0], 1'b0};
                  // RULE_11 wrap to zero at the top
                  addr_r <= (addr_r == MEM_BYTES - 1) ? {AW{1'b0}} : addr_r + 1'b1;
               end
            end
         end
      end
   end

   // status byte image, top nibble reads zero
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_r <= 8'h00;
         busy_r <= 1'b0;
      end else begin
         status_r <= {4'h0, prot_r, latch_r, busy};
         busy_r <= busy;
      end
   end
endmodule

// ==== testbench/spe_monitor.sv ====
/* checker on the serial memory core ports.
 assumes it is bound onto spe_core with its parameters. */
`timescale 1ns/1ns
module spe_monitor #(
   parameter MEM_BYTES = 512,
   parameter PAGE_BYTES = 16,
   parameter TW_CYC = 200
) (
   input wire ref_clk,
   input wire resetn,
   input wire sel_n,
   input wire sclk,
   input wire sdi,
   input wire wp_n,
   input wire sdo_r,
   input wire sdo_oe_r,
   input wire busy_r,
   input wire [7:0] status_r
);
   int busy_cnt_r;
   // length of the current busy stretch, so a short program time shows
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         busy_cnt_r <= 0;
      else
         busy_cnt_r <= busy_r ? busy_cnt_r + 1 : 0;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_busy_after_sel: assert property ($rose(busy_r) |-> sel_n && $past(sel_n, 2))
      else $error("busy began while selected");
   a_busy_min_len: assert property ($fell(busy_r) |-> busy_cnt_r >= TW_CYC)
      else $error("program cycle too short");
   a_busy_in_status: assert property (busy_r |-> ##[0:1] status_r[0])
      else $error("status busy bit low while busy");
   a_top_nibble_zero: assert property (status_r[7:4] == 4'h0)
      else $error("status top nibble not zero");
   a_latch_clear_end: assert property ($fell(busy_r) |-> ##[0:2] !status_r[1])
      else $error("latch still set after cycle");
   a_protect_hold: assert property (busy_r && $past(busy_r) |-> $stable(status_r[3:2]))
      else $error("protect bits moved mid cycle");
   a_oe_off_desel: assert property (sel_n [*8] |-> !sdo_oe_r)
      else $error("output driven while deselected");
   a_busy_needs_wp: assert property ($rose(busy_r) |-> wp_n && $past(wp_n, 3))
      else $error("cycle started with protect pin low");
endmodule
bind spe_core spe_monitor #(.MEM_BYTES(MEM_BYTES), .PAGE_BYTES(PAGE_BYTES), .TW_CYC(TW_CYC)) spe_monitor_i (
   .ref_clk(ref_clk), .resetn(resetn), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .wp_n(wp_n),
   .sdo_r(sdo_r), .sdo_oe_r(sdo_oe_r), .busy_r(busy_r), .status_r(status_r));

// ==== testbench/spe_master.sv ====
/* spi master model, mode 0, 125 ns link clock.
 assumes the bench opens, shifts and closes frames in turn. */
`timescale 1ns/1ns
module spe_master (
   output logic sel_n,
   output logic sclk,
   output logic sdi,
   input wire sdo
);
   // link idle: clock stands low, select high
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   task automatic open_frame;
      #2 sel_n = 1'b0;
      #40;
   endtask
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      for (int i = 0; i < n; i++) begin
         sdi = tx[7-i];
         #62 sclk = 1'b1;
         rx = {rx[6:0], sdo};
         #63 sclk = 1'b0;
      end
   endtask
   task automatic close_frame;
      #30 sel_n = 1'b1;
      sdi = ~sdi; // released line must not keep its last value
      #100;
   endtask
endmodule

// ==== testbench/tb_spi_eeprom_rw_status_logic.sv ====
/* self-checking bench for the serial memory command logic.
 assumes the mode 0 master model and a 200 cycle program time. */
`timescale 1ns/1ns
module tb_spi_eeprom_rw_status_logic;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic wp_n = 1'b1;
   wire sel_n, sclk, sdi, sdo_r, sdo_oe_r, busy_r;
   wire [7:0] status_r;
   int bad_count = 0;
   int num_checks = 0;
   logic [7:0] q[$];
   logic [7:0] rq[$];
   spe_core #(.TW_CYC(200)) spe_core_i (.ref_clk(ref_clk), .resetn(resetn), .sel_n(sel_n), .sclk(sclk),
      .sdi(sdi), .wp_n(wp_n), .sdo_r(sdo_r), .sdo_oe_r(sdo_oe_r), .busy_r(busy_r), .status_r(status_r));
   // released data line shows the inverse, so a missing output enable cannot pass
   wire sdo_line = sdo_oe_r ? sdo_r : ~sdo_r;
   spe_master spe_master_i (.sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));
   // 100 MHz core clock
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk1(input string w, input logic e, input logic g);
      check(w, {7'h00, e}, {7'h00, g});
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // shift out q, last byte cut to nb bits; bytes seen land in rq
   task automatic frame(input int nb);
      logic [7:0] rx;
      rq = {};
      spe_master_i.open_frame();
      foreach (q[i]) begin
         spe_master_i.shift(q[i], (i == q.size() - 1) ? nb : 8, rx);
         rq.push_back(rx);
      end
   endtask
   task automatic send(input int nb);
      frame(nb);
      spe_master_i.close_frame();
   endtask
   task automatic latch;
      q = {8'h06};
      send(8);
      chk1("latch", 1'b1, status_r[1]);
   endtask
   // bounded wait for the program cycle to end
   task automatic wait_idle;
      for (int i = 0; i < 1000 && busy_r !== 1'b0; i++)
         @(negedge ref_clk);
      if (busy_r !== 1'b0) begin
         bad_count++;
         $display("ERROR busy expected 0 seen %b", busy_r);
         complete_run();
      end
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic s_power;
      check("status", 8'h00, status_r);
      q = {8'h03, 8'h40, 8'h00};
      frame(8);
      chk1("oe", 1'b1, sdo_oe_r);
      check("data", 8'hFF, rq[2]);
      spe_master_i.close_frame();
   endtask
   task automatic s_refuse;
      latch();
      q = {8'h04};
      send(8);
      chk1("latch", 1'b0, status_r[1]);
      q = {8'h02, 8'h10, 8'h55};
      send(8);
      chk1("busy", 1'b0, busy_r);
      q = {8'h01, 8'h0C};
      send(8);
      chk1("busy", 1'b0, busy_r);
   endtask
   task automatic s_page;
      latch();
      q = {8'h0A, 8'hFE, 8'hA1, 8'hA2, 8'hA3};
      send(8);
      chk1("busy", 1'b1, busy_r);
      chk1("stat busy", 1'b1, status_r[0]);
      q = {8'h0B, 8'hFE, 8'h00};
      frame(8);
      chk1("oe", 1'b0, sdo_oe_r);
      spe_master_i.close_frame();
      wait_idle();
      check("status", 8'h00, status_r);
      q = {8'h0B, 8'hFE, 8'h00, 8'h00, 8'h00};
      frame(8);
      spe_master_i.close_frame();
      check("rd 1fe", 8'hA1, rq[2]);
      check("rd 1ff", 8'hA2, rq[3]);
      check("rd 000", 8'hFF, rq[4]);
      q = {8'h0B, 8'hF0, 8'h00, 8'h00};
      send(8);
      check("rd 1f0", 8'hA3, rq[2]);
      check("rd 1f1", 8'hFF, rq[3]);
   endtask
   task automatic s_status;
      latch();
      q = {8'h01, 8'hF4};
      send(8);
      chk1("busy", 1'b1, busy_r);
      check("prot", 8'h00, {6'h00, status_r[3:2]});
      q = {8'h05, 8'h00};
      send(8);
      check("rd status", 8'h03, rq[1]);
      wait_idle();
      check("status", 8'h04, status_r);
      latch();
      q = {8'h0A, 8'h80, 8'h11};
      send(8);
      chk1("busy", 1'b0, busy_r);
      latch();
      q = {8'h0A, 8'h7F, 8'h22};
      send(8);
      chk1("busy", 1'b1, busy_r);
      wait_idle();
   endtask
   task automatic s_guard;
      latch();
      @(posedge ref_clk) wp_n <= 1'b0;
      q = {8'h01, 8'h00};
      send(8);
      @(posedge ref_clk) wp_n <= 1'b1;
      chk1("busy", 1'b0, busy_r);
      @(posedge ref_clk) resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (5) @(negedge ref_clk);
      check("status", 8'h04, status_r);
      latch();
      q = {8'h01, 8'h00};
      send(4);
      chk1("busy", 1'b0, busy_r);
      q = {8'h07, 8'h02, 8'h10, 8'h00};
      send(8);
      chk1("busy", 1'b0, busy_r);
      latch();
      q = {8'h01, 8'h00};
      send(8);
      wait_idle();
      check("status", 8'h00, status_r);
   endtask
   // reset held 6 cycles, then each scenario in turn
   initial begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      s_power();
      s_refuse();
      s_page();
      s_status();
      s_guard();
      complete_run();
   end
endmodule
